// ===== hdl/dff_cfg.svh
`ifndef DFF_CFG_SVH
`define DFF_CFG_SVH

// Serial frame layout
`define DFF_FRAME_W     32
`define DFF_ADDR_W      7
`define DFF_DATA_W      24
`define DFF_F_WR        31
`define DFF_F_ADDR_HI   30
`define DFF_F_ADDR_LO   24
`define DFF_LAST_BIT    5'h1F
`define DFF_RSP_ERR     7
`define DFF_RSP_UV      2

// Register offsets
`define DFF_A_ERR       7'h04
`define DFF_A_STERR     7'h05
`define DFF_A_CTRL      7'h08
`define DFF_A_LPC1      7'h15
`define DFF_A_LPC2      7'h16
`define DFF_A_NIBC      7'h17
`define DFF_A_UCF1      7'h18
`define DFF_A_UCF2      7'h19
`define DFF_A_MASK      7'h1E
`define DFF_A_SCR       7'h1F
`define DFF_NV_WORDS    7
`define DFF_NV_MASK_IX  3'h5
`define DFF_NV_RST      24'h000000

// Fault register fields
`define DFF_ERR_W       7
`define DFF_ERR_RST     7'h01
`define DFF_B_SUPPLY    0
`define DFF_B_WEAK      1
`define DFF_B_INTERNAL  2
`define DFF_B_OVERTEMP  4
`define DFF_B_MEM_CORR  5
`define DFF_B_MEM_UNC   6

// Second fault register fields
`define DFF_STERR_W     7
`define DFF_STERR_RST   7'h00
`define DFF_B2_RING     3
`define DFF_B2_LOGIC_SELF_TEST    4

// Fault mask word fields
`define DFF_M_SUPPLY    0
`define DFF_M_WEAK      1
`define DFF_M_INTERNAL  2
`define DFF_M_OVERTEMP  4
`define DFF_M_MEM_CORR  5
`define DFF_M_MEM_UNC   6
`define DFF_M_RING      10
`define DFF_M_LOGIC_SELF_TEST     11

// Control register fields
`define DFF_C_CLEAR     0
`define DFF_C_LOGIC_SELF_TEST     1
`define DFF_C_RING      2

// Timing
`define DFF_CLK_KHZ     40000
`define DFF_LOGIC_SELF_TEST_US    10000
`define DFF_RING_ELEMS  64
`define DFF_ELEM_WAIT   256
`define DFF_STEP_TOL    12'h010

`endif

// ===== hdl/dff_pkg.sv
`include "dff_cfg.svh"
package dff_pkg;
  typedef logic [`DFF_ADDR_W-1:0] dff_addr_t;
  typedef logic [`DFF_DATA_W-1:0] dff_word_t;
  typedef logic [11:0]            dff_angle_t;

  typedef enum logic [2:0] {
    DFF_ST_IDLE  = 3'b001,
    DFF_ST_LOGIC_SELF_TEST = 3'b010,
    DFF_ST_RING  = 3'b100
  } dff_state_t;
endpackage : dff_pkg

// ===== hdl/dff_st_if.sv
`timescale 1ns/100ps
interface dff_st_if;
  logic start_logic_self_test;
  logic start_ring;
  logic logic_self_test_busy;
  logic ring_busy;
  logic logic_self_test_done;
  logic logic_self_test_fail;
  logic ring_done;
  logic ring_fail;
  logic illegal;

  modport ctl (output start_logic_self_test, output start_ring,
               input logic_self_test_busy, input ring_busy, input logic_self_test_done,
               input logic_self_test_fail, input ring_done, input ring_fail,
               input illegal);
  modport eng (input start_logic_self_test, input start_ring,
               output logic_self_test_busy, output ring_busy, output logic_self_test_done,
               output logic_self_test_fail, output ring_done, output ring_fail,
               output illegal);
endinterface : dff_st_if

// ===== hdl/dff_selftest.sv
`timescale 1ns/100ps
`include "dff_cfg.svh"
module dff_selftest #(
  parameter int LOGIC_SELF_TEST_CYCLES = 400000,
  parameter int RING_ELEMS   = `DFF_RING_ELEMS,
  parameter int ELEM_WAIT    = `DFF_ELEM_WAIT
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  dff_st_if.eng              st,
  input  wire logic          logic_self_test_ok_i,
  input  wire dff_pkg::dff_angle_t angle_i,
  input  wire logic          angle_valid_i,
  output logic               logic_self_test_run_o,
  output logic               ring_bias_en_o,
  output logic [$clog2(RING_ELEMS)-1:0] ring_elem_o
);
  import dff_pkg::*;

  localparam int EW = $clog2(RING_ELEMS);
  localparam dff_angle_t STEP = dff_angle_t'(4096 / RING_ELEMS);

  if (RING_ELEMS < 2 || RING_ELEMS > 4096 || LOGIC_SELF_TEST_CYCLES < 1 ||
      ELEM_WAIT < 1) begin : g_bad
    $error("dff_selftest: unsupported parameter value");
  end

  function automatic logic step_bad(input dff_angle_t a,
                                    input dff_angle_t b);
    dff_angle_t d;
    d = a - b - STEP;
    if (d[11])
      d = -d;
    return d > `DFF_STEP_TOL;
  endfunction : step_bad

  dff_state_t state;
  logic [31:0] cnt;
  dff_angle_t  angle_mem [RING_ELEMS];
  logic        ring_err;
  logic        elem_bad;

  // Judged on the live sample, so a bad last element still fails the run
  assign elem_bad = !angle_valid_i || (ring_elem_o != '0 &&
                    step_bad(angle_i, angle_mem[ring_elem_o - EW'(1)]));

  ////////////////////////////////////////////////////////////////////////
  // Sequencer; a start while busy is simply not looked at
  always_ff @(posedge clk_i) begin
    st.logic_self_test_done <= 1'b0;
    st.ring_done  <= 1'b0;
    st.illegal    <= 1'b0;
    if (reset_i) begin
      state          <= DFF_ST_IDLE;
      cnt            <= '0;
      ring_err       <= 1'b0;
      logic_self_test_run_o    <= 1'b0;
      ring_bias_en_o <= 1'b0;
      ring_elem_o    <= '0;
      st.logic_self_test_fail  <= 1'b0;
      st.ring_fail   <= 1'b0;
    end else begin
      unique case (state)
        DFF_ST_IDLE: begin
          cnt <= '0;
          if (st.start_logic_self_test) begin
            state       <= DFF_ST_LOGIC_SELF_TEST;
            logic_self_test_run_o <= 1'b1;
          end else if (st.start_ring) begin
            state          <= DFF_ST_RING;
            ring_err       <= 1'b0;
            ring_elem_o    <= '0;
            ring_bias_en_o <= 1'b1;
          end
        end
        DFF_ST_LOGIC_SELF_TEST: begin
          cnt <= cnt + 32'd1;
          if (cnt == 32'(LOGIC_SELF_TEST_CYCLES - 1)) begin
            state         <= DFF_ST_IDLE;
            logic_self_test_run_o   <= 1'b0;
            st.logic_self_test_done <= 1'b1;
            st.logic_self_test_fail <= ~logic_self_test_ok_i;
          end
        end
        DFF_ST_RING: begin
          cnt <= cnt + 32'd1;
          if (angle_valid_i || cnt == 32'(ELEM_WAIT - 1)) begin
            angle_mem[ring_elem_o] <= angle_i;
            cnt <= '0;
            if (elem_bad)
              ring_err <= 1'b1;
            if (ring_elem_o == EW'(RING_ELEMS - 1)) begin
              state          <= DFF_ST_IDLE;
              ring_bias_en_o <= 1'b0;
              st.ring_done   <= 1'b1;
              st.ring_fail   <= ring_err | elem_bad;
            end else begin
              ring_elem_o <= ring_elem_o + EW'(1);
            end
          end
        end
        default: begin
          // Corrupted state code: recover and report it
          state          <= DFF_ST_IDLE;
          logic_self_test_run_o    <= 1'b0;
          ring_bias_en_o <= 1'b0;
          st.illegal     <= 1'b1;
        end
      endcase
    end
  end

  assign st.logic_self_test_busy = state == DFF_ST_LOGIC_SELF_TEST;
  assign st.ring_busy  = state == DFF_ST_RING;
endmodule : dff_selftest

// ===== hdl/dff_top.sv
`timescale 1ns/100ps
`include "dff_cfg.svh"
module dff_top #(
  parameter int LOGIC_SELF_TEST_CYCLES = `DFF_LOGIC_SELF_TEST_US * (`DFF_CLK_KHZ / 1000),
  parameter int RING_ELEMS   = `DFF_RING_ELEMS,
  parameter int ELEM_WAIT    = `DFF_ELEM_WAIT
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          spi_sclk_i,
  input  wire logic          spi_cs_n_i,
  input  wire logic          spi_mosi_i,
  output logic               spi_miso_o,
  output logic               spi_miso_oe_o,
  input  wire logic          nibble_ring_req_i,
  input  wire logic          supply_lost_i,
  input  wire logic          logic_fault_i,
  input  wire logic          weak_field_i,
  input  wire logic          overtemp_i,
  input  wire logic          undervolt_i,
  input  wire logic          nvm_corrected_i,
  input  wire logic          nvm_uncorrectable_i,
  input  wire logic          logic_self_test_ok_i,
  input  wire dff_pkg::dff_angle_t angle_i,
  input  wire logic          angle_valid_i,
  output logic               logic_self_test_run_o,
  output logic               ring_bias_en_o,
  output logic [$clog2(RING_ELEMS)-1:0] ring_elem_o,
  output logic               fault_ind_o
);
  import dff_pkg::*;

  if (LOGIC_SELF_TEST_CYCLES < 1 || RING_ELEMS < 2) begin : g_bad
    $error("dff_top: unsupported parameter value");
  end

  // Offset to nonvolatile word slot; bit 3 marks a hit
  function automatic logic [3:0] nv_slot(input dff_addr_t a);
    unique case (a)
      `DFF_A_LPC1: return 4'h8;
      `DFF_A_LPC2: return 4'h9;
      `DFF_A_NIBC: return 4'hA;
      `DFF_A_UCF1: return 4'hB;
      `DFF_A_UCF2: return 4'hC;
      `DFF_A_MASK: return 4'hD;
      `DFF_A_SCR:  return 4'hE;
      default:     return 4'h0;
    endcase
  endfunction : nv_slot

  ////////////////////////////////////////////////////////////////////////
  // Link domain: mode 3 serial slave, runs only while a frame is open
  logic       link_clr;
  logic [4:0] bit_cnt;
  logic [`DFF_FRAME_W-1:0] rx_sh;
  logic [`DFF_FRAME_W-1:0] rx_hold;
  logic       rx_tgl;
  logic [`DFF_FRAME_W-2:0] tx_sh;
  logic [`DFF_FRAME_W-1:0] rsp_word;

  // Frame select ends the frame; reset covers the idle state
  assign link_clr = spi_cs_n_i | reset_i;

  always_ff @(posedge spi_sclk_i or posedge link_clr) begin
    if (link_clr)
      bit_cnt <= '0;
    else
      bit_cnt <= bit_cnt + 5'h01;
  end

  always_ff @(posedge spi_sclk_i) begin
    rx_sh <= {rx_sh[`DFF_FRAME_W-2:0], spi_mosi_i};
  end

  // Whole frame held and announced by a toggle
  always_ff @(posedge spi_sclk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_hold <= '0;
      rx_tgl  <= 1'b0;
    end else if (bit_cnt == `DFF_LAST_BIT) begin
      rx_hold <= {rx_sh[`DFF_FRAME_W-2:0], spi_mosi_i};
      rx_tgl  <= ~rx_tgl;
    end
  end

  // First falling edge of a frame loads the response word; it is
  // frozen while the frame is open, so no crossing logic is needed
  always_ff @(negedge spi_sclk_i or posedge link_clr) begin
    if (link_clr) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
      tx_sh         <= '0;
    end else begin
      spi_miso_oe_o <= 1'b1;
      if (bit_cnt == 5'h00)
        {spi_miso_o, tx_sh} <= rsp_word;
      else
        {spi_miso_o, tx_sh} <= {tx_sh, 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NP = 10;
  logic [NP-1:0] pin_s1;
  logic [NP-1:0] pin_s2;
  logic          tgl_s1;
  logic          tgl_s2;
  logic          tgl_s3;
  logic          nib_d;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      nib_d  <= 1'b0;
    end else begin
      pin_s1 <= {spi_cs_n_i, nibble_ring_req_i, supply_lost_i,
                 logic_fault_i, weak_field_i, overtemp_i, undervolt_i,
                 nvm_corrected_i, nvm_uncorrectable_i, logic_self_test_ok_i};
      pin_s2 <= pin_s1;
      tgl_s1 <= rx_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      nib_d  <= pin_s2[8];
    end
  end

  logic cs_idle;
  logic nib_s;
  logic lost_s;
  logic lfault_s;
  logic weak_s;
  logic hot_s;
  logic uv_s;
  logic corr_s;
  logic unc_s;
  logic lbok_s;
  assign {cs_idle, nib_s, lost_s, lfault_s, weak_s, hot_s, uv_s,
          corr_s, unc_s, lbok_s} = pin_s2;

  ////////////////////////////////////////////////////////////////////////
  // Frame decode
  logic      frame_v;
  logic      f_wr;
  dff_addr_t f_addr;
  dff_word_t f_data;
  logic [3:0] f_slot;
  logic      ctrl_wr;

  assign frame_v = tgl_s2 ^ tgl_s3;
  assign f_wr    = rx_hold[`DFF_F_WR];
  assign f_addr  = rx_hold[`DFF_F_ADDR_HI:`DFF_F_ADDR_LO];
  assign f_data  = rx_hold[`DFF_DATA_W-1:0];
  assign f_slot  = nv_slot(f_addr);
  assign ctrl_wr = frame_v & f_wr & (f_addr == `DFF_A_CTRL);

  dff_st_if st ();

  logic clr_faults;
  assign clr_faults     = ctrl_wr & f_data[`DFF_C_CLEAR];
  assign st.start_logic_self_test = ctrl_wr & f_data[`DFF_C_LOGIC_SELF_TEST];
  // Either link may request the ring test
  assign st.start_ring  = (ctrl_wr & f_data[`DFF_C_RING]) |
                          (nib_s & ~nib_d);

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile configuration words
  dff_word_t nv_mem [`DFF_NV_WORDS];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `DFF_NV_WORDS; i++)
        nv_mem[i] <= `DFF_NV_RST;
    end else if (frame_v && f_wr && f_slot[3]) begin
      nv_mem[f_slot[2:0]] <= f_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault flags; a set in the clearing cycle wins
  logic [`DFF_ERR_W-1:0]  err;
  logic [`DFF_ERR_W-1:0]  err_set;
  logic [`DFF_STERR_W-1:0] st_err;

  always_comb begin
    err_set = '0;
    err_set[`DFF_B_SUPPLY]   = lost_s;
    err_set[`DFF_B_WEAK]     = weak_s;
    err_set[`DFF_B_INTERNAL] = lfault_s | st.illegal;
    err_set[`DFF_B_OVERTEMP] = hot_s;
    err_set[`DFF_B_MEM_CORR] = corr_s;
    err_set[`DFF_B_MEM_UNC]  = unc_s;
  end

  // Supply loss powers up set, since a fresh start follows a supply loss
  always_ff @(posedge clk_i) begin
    if (reset_i)
      err <= `DFF_ERR_RST;
    else
      err <= (err & ~{`DFF_ERR_W{clr_faults}}) | err_set;
  end

  // Logic self-test outcome overwrites on completion, a ring fail only sets; else stick
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_err <= `DFF_STERR_RST;
    end else begin
      if (clr_faults)
        st_err <= '0;
      if (st.logic_self_test_done)
        st_err[`DFF_B2_LOGIC_SELF_TEST] <= st.logic_self_test_fail;
      else if (clr_faults)
        st_err[`DFF_B2_LOGIC_SELF_TEST] <= 1'b0;
      if (st.ring_done && st.ring_fail)
        st_err[`DFF_B2_RING] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error indication and responses
  dff_word_t mask;
  logic      err_ind;
  assign mask = nv_mem[`DFF_NV_MASK_IX];
  assign err_ind =
      (err[`DFF_B_SUPPLY]   & ~mask[`DFF_M_SUPPLY])   |
      (err[`DFF_B_WEAK]     & ~mask[`DFF_M_WEAK])     |
      (err[`DFF_B_INTERNAL] & ~mask[`DFF_M_INTERNAL]) |
      (err[`DFF_B_OVERTEMP] & ~mask[`DFF_M_OVERTEMP]) |
      (err[`DFF_B_MEM_CORR] & ~mask[`DFF_M_MEM_CORR]) |
      (err[`DFF_B_MEM_UNC]  & ~mask[`DFF_M_MEM_UNC])  |
      (st_err[`DFF_B2_RING]  & ~mask[`DFF_M_RING])    |
      (st_err[`DFF_B2_LOGIC_SELF_TEST] & ~mask[`DFF_M_LOGIC_SELF_TEST]);

  dff_word_t rd_data;
  dff_word_t rd_hold;

  always_comb begin
    rd_data = '0;
    if (f_slot[3])
      rd_data = nv_mem[f_slot[2:0]];
    else if (f_addr == `DFF_A_ERR)
      rd_data[`DFF_ERR_W-1:0] = err;
    else if (f_addr == `DFF_A_STERR)
      rd_data[`DFF_STERR_W-1:0] = st_err;
    else if (f_addr == `DFF_A_CTRL) begin
      rd_data[`DFF_C_LOGIC_SELF_TEST] = st.logic_self_test_busy;
      rd_data[`DFF_C_RING]  = st.ring_busy;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i)
      rd_hold <= '0;
    else if (frame_v)
      rd_hold <= rd_data;
  end

  // Only refreshed while no frame is open, so the link sees it still
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rsp_word <= '0;
    end else if (cs_idle) begin
      rsp_word <= '0;
      rsp_word[`DFF_FRAME_W-1:`DFF_FRAME_W-`DFF_DATA_W] <= rd_hold;
      rsp_word[`DFF_RSP_ERR] <= err_ind;
      rsp_word[`DFF_RSP_UV]  <= uv_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i)
      fault_ind_o <= 1'b0;
    else
      fault_ind_o <= err_ind;
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-test engine
  dff_selftest #(
    .LOGIC_SELF_TEST_CYCLES (LOGIC_SELF_TEST_CYCLES),
    .RING_ELEMS   (RING_ELEMS),
    .ELEM_WAIT    (ELEM_WAIT)
  ) u_selftest (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .st             (st),
    .logic_self_test_ok_i     (lbok_s),
    .angle_i        (angle_i),
    .angle_valid_i  (angle_valid_i),
    .logic_self_test_run_o    (logic_self_test_run_o),
    .ring_bias_en_o (ring_bias_en_o),
    .ring_elem_o    (ring_elem_o)
  );
endmodule : dff_top

// ===== testbench/dff_host.sv
`timescale 1ns/100ps
module dff_host (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  // A released MISO reads as the pull-up level, never the last bit
  wire miso_line = miso_oe_i ? miso_i : 1'b1;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Whole 32-bit frame, MSB first, mode 3; clock stands still between frames
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    #3.1 cs_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      #62.5 sclk_o = 1'b0;
      mosi_o = w[i];
      #62.5 sclk_o = 1'b1;
      r[i] = miso_line;
    end
    #62.5 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    // Gap well above the response refresh time
    #500;
  endtask : xfer
endmodule : dff_host

// ===== testbench/dff_asserts.sv
`timescale 1ns/100ps
module dff_asserts #(
  parameter int LOGIC_SELF_TEST_CYCLES = 20,
  parameter int RING_ELEMS   = 64,
  parameter int ELEM_WAIT    = 256
) (
  input wire logic                          clk_i,
  input wire logic                          reset_i,
  input wire logic                          spi_cs_n_i,
  input wire logic                          spi_miso_o,
  input wire logic                          spi_miso_oe_o,
  input wire logic                          nibble_ring_req_i,
  input wire logic                          logic_self_test_run_o,
  input wire logic                          ring_bias_en_o,
  input wire logic [$clog2(RING_ELEMS)-1:0] ring_elem_o
);
  localparam int EW       = $clog2(RING_ELEMS);
  localparam int RING_MAX = RING_ELEMS * (ELEM_WAIT + 4);
  int            lb_cnt;
  int            rg_cnt;
  int            el_cnt;
  logic [EW-1:0] elem_q;
  always_ff @(posedge clk_i) begin
    lb_cnt <= (reset_i || !logic_self_test_run_o) ? 0 : lb_cnt + 1;
    rg_cnt <= (reset_i || !ring_bias_en_o) ? 0 : rg_cnt + 1;
    el_cnt <= (!ring_bias_en_o || ring_elem_o != elem_q) ? 0 : el_cnt + 1;
    elem_q <= ring_elem_o;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_cs_idle;
    spi_cs_n_i ##1 spi_cs_n_i;
  endsequence
  sequence s_nib_req;
    !logic_self_test_run_o && !ring_bias_en_o ##1 $rose(nibble_ring_req_i);
  endsequence
  chk_link_idle: assert property (
    s_cs_idle |=> !spi_miso_oe_o && !spi_miso_o)
    else $error("miso active outside a frame");
  chk_nibble_start: assert property (
    s_nib_req |-> ##[1:8] ring_bias_en_o)
    else $error("nibble request did not start ring test");
  chk_ring_first: assert property (
    $rose(ring_bias_en_o) |-> ring_elem_o == '0)
    else $error("ring test did not begin at element 0");
  chk_ring_step: assert property (
    ring_bias_en_o && ring_elem_o != $past(ring_elem_o) |->
      ring_elem_o == EW'($past(ring_elem_o) + 1))
    else $error("ring element skipped");
  chk_ring_total: assert property (
    ring_bias_en_o |-> rg_cnt < RING_MAX)
    else $error("ring test too long");
  chk_elem_wait: assert property (
    ring_bias_en_o |-> el_cnt <= ELEM_WAIT + 4)
    else $error("ring element wait too long");
  chk_logic_self_test_len: assert property (
    $fell(logic_self_test_run_o) |-> lb_cnt inside {[LOGIC_SELF_TEST_CYCLES-1:LOGIC_SELF_TEST_CYCLES+1]})
    else $error("logic self-test length wrong");
  chk_logic_self_test_bound: assert property (
    logic_self_test_run_o |-> lb_cnt <= LOGIC_SELF_TEST_CYCLES + 1)
    else $error("logic self-test overran");
  chk_one_test: assert property (
    !(logic_self_test_run_o && ring_bias_en_o))
    else $error("two self-tests running at once");
endmodule : dff_asserts
bind dff_top dff_asserts #(
  .LOGIC_SELF_TEST_CYCLES(LOGIC_SELF_TEST_CYCLES),
  .RING_ELEMS  (RING_ELEMS),
  .ELEM_WAIT   (ELEM_WAIT)
) u_dff_asserts (
  .clk_i            (clk_i),
  .reset_i          (reset_i),
  .spi_cs_n_i       (spi_cs_n_i),
  .spi_miso_o       (spi_miso_o),
  .spi_miso_oe_o    (spi_miso_oe_o),
  .nibble_ring_req_i(nibble_ring_req_i),
  .logic_self_test_run_o      (logic_self_test_run_o),
  .ring_bias_en_o   (ring_bias_en_o),
  .ring_elem_o      (ring_elem_o)
);

// ===== testbench/tb.sv
`timescale 1ns/100ps
`include "dff_cfg.svh"
module tb;
  import dff_pkg::*;
  localparam int LB_N = 400;
  localparam int RG_N = 8;
  localparam int STEP = 4096 / RG_N;
  localparam int A_DLY = 40;
  logic clk_i, reset_i = 1'b1, sclk, cs_n, mosi, miso, miso_oe;
  logic nib_req = 1'b0, uv = 1'b0, lb_ok = 1'b0, ang_v = 1'b0, bad = 1'b0;
  logic lb_run, bias, ind;
  logic [5:0] flt = 6'h00;
  dff_angle_t ang = 12'h000;
  logic [$clog2(RG_N)-1:0] elem;
  int fails = 0, check_count = 0, cyc = 0, a_cnt = 0, bad_el = 3;
  logic [31:0] seed, rsp;
  logic [6:0] exp_e;
  int bpos[6] = '{0, 1, 2, 4, 5, 6};
  dff_addr_t ra[7] = '{`DFF_A_LPC1, `DFF_A_LPC2, `DFF_A_NIBC, `DFF_A_UCF1,
                       `DFF_A_UCF2, `DFF_A_SCR, `DFF_A_MASK};
  dff_host u_dff_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
                       .miso_i(miso), .miso_oe_i(miso_oe));
  dff_top #(.LOGIC_SELF_TEST_CYCLES(LB_N), .RING_ELEMS(RG_N), .ELEM_WAIT(64)) u_dff_top (
    .clk_i(clk_i), .reset_i(reset_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
    .nibble_ring_req_i(nib_req), .supply_lost_i(flt[0]),
    .weak_field_i(flt[1]), .logic_fault_i(flt[2]), .overtemp_i(flt[3]),
    .nvm_corrected_i(flt[4]), .nvm_uncorrectable_i(flt[5]),
    .undervolt_i(uv), .logic_self_test_ok_i(lb_ok), .angle_i(ang),
    .angle_valid_i(ang_v), .logic_self_test_run_o(lb_run), .ring_bias_en_o(bias),
    .ring_elem_o(elem), .fault_ind_o(ind));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Signal path answers each biased element late; bad bends one element
  always @(posedge clk_i) begin
    ang_v <= 1'b0;
    a_cnt <= bias ? a_cnt + 1 : 0;
    if (bias && a_cnt == A_DLY) begin
      ang_v <= 1'b1;
      ang <= dff_angle_t'(elem * STEP) +
             ((bad && elem == bad_el) ? 12'h040 : 12'h000);
      a_cnt <= 0;
    end
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk
  task automatic wr(input dff_addr_t a, input dff_word_t d);
    logic [31:0] r;
    u_dff_host.xfer({1'b1, a, d}, r);
  endtask : wr
  // Answer of a frame comes back in the next one
  task automatic rd(input dff_addr_t a, output logic [31:0] r);
    u_dff_host.xfer({1'b0, a, 24'h000000}, r);
    u_dff_host.xfer({1'b0, `DFF_A_ERR, 24'h000000}, r);
  endtask : rd
  task automatic rchk(input string nm, input dff_addr_t a, input dff_word_t e);
    rd(a, rsp);
    chk(nm, e, rsp[31:8]);
  endtask : rchk
  task automatic wait_on(input logic which, input logic v);
    for (int i = 0; i < 2000 && (which ? bias : lb_run) !== v; i++)
      @(posedge clk_i);
    chk(which ? "ring busy" : "logic_self_test busy", v, which ? bias : lb_run);
  endtask : wait_on
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk("err reset", `DFF_A_ERR, 24'h000001);
    rchk("st err reset", `DFF_A_STERR, 24'h000000);
    chk("ind reset", 1'b1, ind);
    rchk("unmapped", 7'h30, 24'h000000);
    $display("test reset done");
    seed = 32'hE93A507B;
    for (int i = 0; i < 7; i++) begin
      rchk("nv reset", ra[i], 24'h000000);
      seed = lfsr(seed);
      wr(ra[i], seed[23:0]);
      rchk("nv word", ra[i], seed[23:0]);
    end
    wr(`DFF_A_MASK, 24'h000000);
    wr(`DFF_A_ERR, 24'h00007E);
    rchk("err read only", `DFF_A_ERR, 24'h000001);
    $display("test registers done");
    wr(`DFF_A_CTRL, 24'h000001);
    rchk("err clear", `DFF_A_ERR, 24'h000000);
    exp_e = 7'h00;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i) flt[i] <= 1'b1;
      repeat (4) @(posedge clk_i);
      flt[i] <= 1'b0;
      exp_e[bpos[i]] = 1'b1;
      rchk("flag", `DFF_A_ERR, {17'h00000, exp_e});
      chk("ind set", 1'b1, ind);
    end
    $display("test flags done");
    wr(`DFF_A_MASK, 24'h000077);
    chk("ind masked", 1'b0, ind);
    rchk("err masked", `DFF_A_ERR, 24'h000077);
    wr(`DFF_A_MASK, 24'h000076);
    chk("ind unmasked", 1'b1, ind);
    @(posedge clk_i) uv <= 1'b1;
    rd(`DFF_A_ERR, rsp);
    chk("rsp low bits", 8'h84, rsp[7:0]);
    @(posedge clk_i) uv <= 1'b0;
    wr(`DFF_A_MASK, 24'h000077);
    rd(`DFF_A_ERR, rsp);
    chk("rsp quiet", 8'h00, rsp[7:0]);
    wr(`DFF_A_MASK, 24'h000000);
    wr(`DFF_A_CTRL, 24'h000001);
    $display("test mask done");
    wr(`DFF_A_CTRL, 24'h000002);
    wait_on(1'b0, 1'b1);
    wr(`DFF_A_CTRL, 24'h000004);
    chk("ring ignored", 1'b0, bias);
    chk("logic_self_test kept", 1'b1, lb_run);
    rchk("ctrl busy", `DFF_A_CTRL, 24'h000002);
    wait_on(1'b0, 1'b0);
    rchk("logic_self_test fail", `DFF_A_STERR, 24'h000010);
    chk("ind logic_self_test", 1'b1, ind);
    @(posedge clk_i) lb_ok <= 1'b1;
    wr(`DFF_A_CTRL, 24'h000002);
    wait_on(1'b0, 1'b0);
    rchk("logic_self_test pass", `DFF_A_STERR, 24'h000000);
    $display("test logic self-test done");
    @(posedge clk_i) nib_req <= 1'b1;
    wait_on(1'b1, 1'b1);
    wr(`DFF_A_CTRL, 24'h000002);
    chk("logic_self_test ignored", 1'b0, lb_run);
    wait_on(1'b1, 1'b0);
    nib_req <= 1'b0;
    rchk("ring pass", `DFF_A_STERR, 24'h000000);
    @(posedge clk_i) bad <= 1'b1;
    wr(`DFF_A_CTRL, 24'h000004);
    wait_on(1'b1, 1'b0);
    rchk("ring fail", `DFF_A_STERR, 24'h000008);
    chk("ind ring", 1'b1, ind);
    wr(`DFF_A_CTRL, 24'h000001);
    rchk("st err clear", `DFF_A_STERR, 24'h000000);
    // Bend only the last element: its step must still fail the run
    @(posedge clk_i) bad_el <= RG_N - 1;
    wr(`DFF_A_CTRL, 24'h000004);
    wait_on(1'b1, 1'b0);
    rchk("ring last", `DFF_A_STERR, 24'h000008);
    $display("test ring done");
    final_report();
  end
endmodule : tb
